// ### hdl/lcd_regs.svh
/*
  Register addresses, field positions, reset values and timing figures of the
  segment display driver. Definitions only; included by the driver files.
*/
`ifndef LCD_REGS_SVH
`define LCD_REGS_SVH

// register map in the external data space
`define LCD_ADDR_CONFIG 16'hFEDC
`define LCD_ADDR_OUT_BASE 16'hFEDD
`define LCD_ADDR_OUT_LAST 16'hFEFC
`define LCD_ADDR_CONTRAST 16'hFEFD
`define LCD_OUT_HOLE 5'h1C

// reset values and writable bits
`define LCD_CONFIG_RESET 8'h47
`define LCD_CONTRAST_RESET 8'h03
`define LCD_OUT_RESET 8'h00
`define LCD_CONFIG_MASK 8'h7F
`define LCD_CONTRAST_MASK 8'h0F
`define LCD_BANK_TOP_MASK 8'h7F
`define LCD_BANK_FULL_MASK 8'hFF
`define LCD_HOLE_MASK 8'h00

// configuration fields
`define LCD_CFG_M_LSB 0
`define LCD_CFG_EN_BIT 3
`define LCD_CFG_C_LSB 4

// dimmer input selection codes that float upper pins
`define LCD_DIM_ALL_HIZ 3'h0
`define LCD_DIM_SEG_HIZ 3'h6
`define LCD_DIM_BP_HIZ 3'h7
`define LCD_SEG_UPPER_LSB 20
`define LCD_BP_UPPER_LSB 4

// time spent on one backplane, and the system clock
`define LCD_PHASE_TIME_US 500
`define LCD_CLK_MHZ 100

`endif

// ### hdl/lcd_pkg.sv
/*
  Types of the segment display driver: state records and generator states.
  Assumes the constants of lcd_regs.svh alongside.
*/
package lcd_pkg;

  typedef enum logic [0:0] {LCD_WV_HALT, LCD_WV_RUN} lcd_wave_state_e;

  // generator state
  typedef struct packed {
    lcd_wave_state_e st;
    logic [23:0] cnt;
    logic [2:0] phase;
    logic pol;
  } lcd_wave_s;

  // driver state: registers, read data and registered pins
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] contrast;
    logic [31:0][7:0] mem;
    logic [7:0] rdata;
    logic [23:0] seg_out;
    logic [23:0] seg_oe;
    logic [7:0] bp_out;
    logic [7:0] bp_oe;
  } lcd_top_s;

endpackage : lcd_pkg

// ### hdl/lcd_if.sv
/*
  Carrier between the driver's register side and its waveform generator.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface lcd_if;
  logic en;
  logic [2:0] bp_last;
  logic [2:0] phase;
  logic pol;

  modport ctrl (output en, output bp_last, input phase, input pol);
  modport gen (input en, input bp_last, output phase, output pol);
endinterface : lcd_if

// ### hdl/lcd_wave.sv
/*
  Waveform timing generator: steps through the active backplanes and flips
  the drive polarity every frame. Assumes clk_sys and a synchronous reset.
*/
`timescale 1ns/1ps
`include "lcd_regs.svh"
module lcd_wave #(
  parameter int PHASE_CYCLES = 50000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // link to the register side
  lcd_if.gen lnk
);

  generate
    if (PHASE_CYCLES < 1 || PHASE_CYCLES > 24'hFFFFFF)
    begin : g_bad
      $error("lcd_wave: PHASE_CYCLES out of range");
    end
  endgenerate

  localparam logic [23:0] PHASE_LAST = 24'(PHASE_CYCLES - 1);

  lcd_pkg::lcd_wave_s r;
  lcd_pkg::lcd_wave_s next_r;

  // phase stepping; halted and parked at backplane zero while disabled
  always_comb
  begin
    next_r = r;
    case (r.st)
      lcd_pkg::LCD_WV_HALT:
      begin
        next_r.cnt = 24'h000000;
        next_r.phase = 3'h0;
        next_r.pol = 1'b0;
        if (lnk.en)
          next_r.st = lcd_pkg::LCD_WV_RUN;
      end
      lcd_pkg::LCD_WV_RUN:
      begin
        if (!lnk.en)
          next_r.st = lcd_pkg::LCD_WV_HALT;
        else if (r.phase > lnk.bp_last)
        begin
          // a smaller count strands the phase; restart the frame at once
          next_r.cnt = 24'h000000;
          next_r.phase = 3'h0;
          next_r.pol = ~r.pol;
        end
        else if (r.cnt == PHASE_LAST)
        begin
          next_r.cnt = 24'h000000;
          // wrap after the selected count so only N backplanes take turns
          if (r.phase >= lnk.bp_last)
          begin
            next_r.phase = 3'h0;
            next_r.pol = ~r.pol; // flip keeps the glass free of dc
          end
          else
            next_r.phase = r.phase + 3'h1;
        end
        else
          next_r.cnt = r.cnt + 24'h000001;
      end
      default: next_r.st = lcd_pkg::LCD_WV_HALT;
    endcase
  end

  // no power-mode gating here: the panel stays driven in every mode
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      r <= '{st: lcd_pkg::LCD_WV_HALT, cnt: 24'h000000, phase: 3'h0, pol: 1'b0};
    else
      r <= next_r;
  end

  assign lnk.phase = r.phase;
  assign lnk.pol = r.pol;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_step_due;
    r.st == lcd_pkg::LCD_WV_RUN && lnk.en && r.cnt == PHASE_LAST;
  endsequence

  sequence s_wrapped;
    r.phase == 3'h0 && r.pol != $past(r.pol);
  endsequence

  a_phase_in_range: assert property (
    r.st == lcd_pkg::LCD_WV_RUN |-> r.phase <= lnk.bp_last || $changed(lnk.bp_last))
    else $error("phase beyond selected backplane count");
  a_frame_wrap: assert property (
    s_step_due ##0 (r.phase == lnk.bp_last) |=> s_wrapped)
    else $error("frame did not wrap with polarity flip");
  a_halt_parks: assert property (
    !lnk.en ##1 !lnk.en |=> r.phase == 3'h0 && r.cnt == 24'h000000)
    else $error("generator not halted while disabled");

endmodule : lcd_wave

// ### hdl/lcd_driver.sv
/*
  Multiplexed segment display driver: registers in the external data space,
  segment on/off banks and the 32 display pins with their float enables.
  Assumes a single-cycle data-space bus synchronous to clk_sys and a dimmer
  input selection supplied by the dimmer block.
*/
`timescale 1ns/1ps
`include "lcd_regs.svh"
module lcd_driver #(
  parameter int PHASE_CYCLES = `LCD_PHASE_TIME_US * `LCD_CLK_MHZ
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // external data space access
  input wire logic [15:0] xaddr,
  input wire logic [7:0] xwdata,
  input wire logic xwr,
  input wire logic xrd,
  output logic [7:0] xrdata,
  // dimmer input selection from the dimmer block
  input wire logic [2:0] dimmer_input_select,
  // display pins
  output logic [23:0] seg_out,
  output logic [23:0] seg_oe,
  output logic [7:0] common_plane_pins_out,
  output logic [7:0] common_plane_pins_oe,
  // bias settings for the analog drive stage
  output logic [2:0] consumption_code,
  output logic [3:0] contrast_code
);

  lcd_pkg::lcd_top_s r;
  lcd_pkg::lcd_top_s next_r;
  lcd_if lnk ();

  lcd_wave #(
    .PHASE_CYCLES(PHASE_CYCLES)
  ) u_wave (
    .clk_sys(clk_sys),
    .reset(reset),
    .lnk(lnk)
  );

  // writable bits of a bank byte; the row-seven high byte is a hole
  function automatic logic [7:0] bank_mask(input logic [4:0] idx);
    if (idx == `LCD_OUT_HOLE)
      return `LCD_HOLE_MASK;
    else if (idx[1:0] == 2'h0)
      return `LCD_BANK_TOP_MASK;
    else
      return `LCD_BANK_FULL_MASK;
  endfunction : bank_mask

  // bank bit of segment x on backplane p: four bytes per backplane, high first
  function automatic logic seg_bit(input logic [31:0][7:0] mem, input logic [2:0] p,
                                   input logic [4:0] x);
    logic [4:0] idx;
    idx = {p, ~x[4:3]};
    return mem[idx][x[2:0]];
  endfunction : seg_bit

  // drive of a segment pin in the current phase; on means opposite the plane
  function automatic logic seg_drive(input logic [31:0][7:0] mem, input logic [2:0] p,
                                     input logic [4:0] x, input logic pol);
    return seg_bit(mem, p, x) ? ~pol : pol;
  endfunction : seg_drive

  logic in_bank;
  logic [4:0] bank_idx;
  logic [2:0] bp_last;
  logic en;

  // address decode of the bank window
  always_comb
  begin
    in_bank = (xaddr >= `LCD_ADDR_OUT_BASE) && (xaddr <= `LCD_ADDR_OUT_LAST);
    bank_idx = 5'(xaddr - `LCD_ADDR_OUT_BASE);
    bp_last = r.cfg[`LCD_CFG_M_LSB +: 3];
    en = r.cfg[`LCD_CFG_EN_BIT];
  end

  assign lnk.en = en;
  assign lnk.bp_last = bp_last;

  // registers, read data and pin drive
  always_comb
  begin
    next_r = r;
    // register writes; reserved bits stay zero
    if (xwr)
    begin
      if (xaddr == `LCD_ADDR_CONFIG)
        next_r.cfg = xwdata & `LCD_CONFIG_MASK;
      else if (xaddr == `LCD_ADDR_CONTRAST)
        next_r.contrast = xwdata & `LCD_CONTRAST_MASK;
      else if (in_bank)
        next_r.mem[bank_idx] = xwdata & bank_mask(bank_idx);
    end
    // reads answer the next cycle; unmapped addresses read zero
    if (xrd)
    begin
      if (xaddr == `LCD_ADDR_CONFIG)
        next_r.rdata = r.cfg;
      else if (xaddr == `LCD_ADDR_CONTRAST)
        next_r.rdata = r.contrast;
      else if (in_bank)
        next_r.rdata = r.mem[bank_idx];
      else
        next_r.rdata = 8'h00;
    end
    // segment-only pins carry segments 0 to 23
    for (int j = 0; j < 24; j++)
    begin
      next_r.seg_out[j] = en ? seg_drive(r.mem, lnk.phase, 5'(j), lnk.pol) : 1'b1;
    end
    // switchable pins: plane while k is at most the count code, else segment 23+k
    for (int k = 0; k < 8; k++)
    begin
      if (!en)
        next_r.bp_out[k] = 1'b1;
      else if (3'(k) <= bp_last)
        next_r.bp_out[k] = (3'(k) == lnk.phase) ? lnk.pol : ~lnk.pol;
      else
        next_r.bp_out[k] = seg_drive(r.mem, lnk.phase, 5'(23 + k), lnk.pol);
    end
    // upper pins float while the dimmer block claims them as inputs
    next_r.seg_oe = '1;
    next_r.bp_oe = '1;
    if (dimmer_input_select == `LCD_DIM_ALL_HIZ || dimmer_input_select == `LCD_DIM_SEG_HIZ)
      next_r.seg_oe[`LCD_SEG_UPPER_LSB +: 4] = 4'h0;
    if (dimmer_input_select == `LCD_DIM_ALL_HIZ || dimmer_input_select == `LCD_DIM_BP_HIZ)
      next_r.bp_oe[`LCD_BP_UPPER_LSB +: 4] = 4'h0;
  end

  // state register; pins come up driven high, upper pins floating
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      r.cfg <= `LCD_CONFIG_RESET;
      r.contrast <= `LCD_CONTRAST_RESET;
      r.mem <= {32{`LCD_OUT_RESET}};
      r.rdata <= 8'h00;
      r.seg_out <= '1;
      r.seg_oe <= {4'h0, 20'hFFFFF};
      r.bp_out <= '1;
      r.bp_oe <= 8'h0F;
    end
    else
      r <= next_r;
  end

  // outputs taken straight from the state register
  assign xrdata = r.rdata;
  assign seg_out = r.seg_out;
  assign seg_oe = r.seg_oe;
  assign common_plane_pins_out = r.bp_out;
  assign common_plane_pins_oe = r.bp_oe;
  assign consumption_code = r.cfg[`LCD_CFG_C_LSB +: 3];
  assign contrast_code = r.contrast[3:0]; // inverse sense lives in the bias stage

  // helper: number of switchable pins acting as planes
  logic [3:0] plane_count;
  always_comb
  begin
    plane_count = 4'h0;
    for (int k = 0; k < 8; k++)
    begin
      if (3'(k) <= bp_last)
        plane_count = plane_count + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_cfg_write;
    xwr && xaddr == `LCD_ADDR_CONFIG;
  endsequence

  sequence s_enabled_steady;
    en ##1 en && $stable(bp_last);
  endsequence

  a_plane_count: assert property (
    plane_count == 4'({1'b0, bp_last}) + 4'h1)
    else $error("plane count does not follow count code");
  a_pin_zero_plane: assert property (
    s_enabled_steady |=> common_plane_pins_out[0] == ($past(lnk.phase) == 3'h0 ?
                         $past(lnk.pol) : ~$past(lnk.pol)))
    else $error("pin zero not driven as a plane");
  a_cfg_fields: assert property (
    s_cfg_write |=> bp_last == $past(xwdata[2:0]) &&
                    consumption_code == $past(xwdata[6:4]) && r.cfg[7] == 1'b0)
    else $error("configuration fields not taken");
  a_contrast_write: assert property (
    xwr && xaddr == `LCD_ADDR_CONTRAST |=> contrast_code == $past(xwdata[3:0]))
    else $error("contrast code not taken");
  a_disabled_pins: assert property (
    !en ##1 !en |-> seg_out == 24'hFFFFFF && common_plane_pins_out == 8'hFF)
    else $error("pins not parked high while disabled");
  a_dimmer_float: assert property (
    dimmer_input_select == `LCD_DIM_ALL_HIZ |=>
      seg_oe[23:20] == 4'h0 && common_plane_pins_oe[7:4] == 4'h0)
    else $error("upper pins driven while claimed by dimmer");
  a_segment_on: assert property (
    en ##1 en |=> seg_out[0] == ($past(seg_bit(r.mem, lnk.phase, 5'h00)) ?
                  ~$past(lnk.pol) : $past(lnk.pol)))
    else $error("segment zero drive wrong");
  a_read_answer: assert property (
    xrd && xaddr == `LCD_ADDR_CONTRAST |=> xrdata == {4'h0, $past(r.contrast[3:0])})
    else $error("contrast read wrong");

endmodule : lcd_driver

// ### tb/lcd_panel_model.sv
/*
  Passive display glass: counts the cycles in which segment 0 differs from
  plane pins 0 and 1. Assumes the driver's registered pins and one clock.
*/
`timescale 1ns/1ps
module lcd_panel_model (
  // clock and clear
  input wire logic clk_sys,
  input wire logic clear,
  // pins from the driver
  input wire logic [23:0] seg_out,
  input wire logic [7:0] common_plane_pins_out,
  // activity seen at two crossings
  output logic [7:0] lit_cnt0,
  output logic [7:0] lit_cnt1
);
  // glass never drives, it only feels the voltage across each crossing
  always_ff @(posedge clk_sys)
  begin
    if (clear)
    begin
      lit_cnt0 <= 8'h00;
      lit_cnt1 <= 8'h00;
    end
    else
    begin
      lit_cnt0 <= lit_cnt0 + 8'(seg_out[0] ^ common_plane_pins_out[0]);
      lit_cnt1 <= lit_cnt1 + 8'(seg_out[0] ^ common_plane_pins_out[1]);
    end
  end
endmodule : lcd_panel_model

// ### tb/lcd_segment_backplane_driver_test.sv
/*
  Self-checking bench of the segment display driver with a glass model.
  Assumes the driver files and lcd_regs.svh on the include path.
*/
`timescale 1ns/1ps
module lcd_segment_backplane_driver_test;
  typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] r;} lcd_row_s;
  // write value and expected read back; holes and unmapped places read 0
  lcd_row_s rows [8] = '{'{16'hFEDC, 8'hFF, 8'h7F}, '{16'hFEFD, 8'hFF, 8'h0F},
    '{16'hFEDD, 8'hFF, 8'h7F}, '{16'hFEDE, 8'hA5, 8'hA5}, '{16'hFEFC, 8'h3C, 8'h3C},
    '{16'hFEF9, 8'hFF, 8'h00}, '{16'hFEFE, 8'h55, 8'h00}, '{16'hFEDB, 8'h55, 8'h00}};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [15:0] xaddr = 16'h0000;
  logic [7:0] xwdata = 8'h00;
  logic xwr = 1'b0;
  logic xrd = 1'b0;
  logic [2:0] dimmer_input_select = 3'h0;
  logic clear = 1'b1;
  logic [7:0] xrdata;
  logic [23:0] seg_out;
  logic [23:0] seg_oe;
  logic [7:0] pl_out;
  logic [7:0] pl_oe;
  logic [2:0] consumption_code;
  logic [3:0] contrast_code;
  logic [7:0] lit_cnt0;
  logic [7:0] lit_cnt1;
  logic [7:0] rd_val;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // short phases keep the run brief
  lcd_driver #(.PHASE_CYCLES(4)) lcd_driver_inst (.clk_sys(clk_sys), .reset(reset),
    .xaddr(xaddr), .xwdata(xwdata), .xwr(xwr), .xrd(xrd), .xrdata(xrdata),
    .dimmer_input_select(dimmer_input_select), .seg_out(seg_out), .seg_oe(seg_oe),
    .common_plane_pins_out(pl_out), .common_plane_pins_oe(pl_oe),
    .consumption_code(consumption_code), .contrast_code(contrast_code));
  lcd_panel_model lcd_panel_model_inst (.clk_sys(clk_sys), .clear(clear),
    .seg_out(seg_out), .common_plane_pins_out(pl_out), .lit_cnt0(lit_cnt0),
    .lit_cnt1(lit_cnt1));

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  task automatic stop_test();
    $display("compared %0d mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  // one-cycle strobe, held until the sampling edge has passed
  task automatic access(input logic [15:0] a, input logic [7:0] d, input logic wr);
    @(posedge clk_sys);
    #1;
    xaddr = a;
    xwdata = d;
    xwr = wr;
    xrd = ~wr;
    @(posedge clk_sys);
    #1;
    xwr = 1'b0;
    xrd = 1'b0;
    rd_val = xrdata;
  endtask : access

  // a hang ends in the same report
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      stop_test();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    // reset state, dimmer code 000 floats the upper pins
    check(32'(seg_out), 32'h00FFFFFF);
    check(32'(seg_oe), 32'h000FFFFF);
    check(32'(pl_out), 32'h000000FF);
    check(32'(pl_oe), 32'h0000000F);
    check(32'(consumption_code), 32'h4);
    check(32'(contrast_code), 32'h3);
    access(16'hFEDC, 8'h00, 1'b0);
    check(32'(rd_val), 32'h47);
    access(16'hFEFD, 8'h00, 1'b0);
    check(32'(rd_val), 32'h03);
    dimmer_input_select = 3'h1;
    // register table, reserved bits and unmapped places
    foreach (rows[i])
    begin
      access(rows[i].a, rows[i].w, 1'b1);
      access(rows[i].a, 8'h00, 1'b0);
      check(32'(rd_val), 32'(rows[i].r));
    end
    check(32'(consumption_code), 32'h7);
    check(32'(contrast_code), 32'hF);
    // one plane: pin 1 is segment 24 (lit), pin 2 is segment 25 (dark)
    access(16'hFEDD, 8'h01, 1'b1);
    access(16'hFEDC, 8'h48, 1'b1);
    repeat (10) @(posedge clk_sys);
    repeat (8)
    begin
      @(posedge clk_sys);
      #1;
      check(32'(pl_out[1] ^ pl_out[0]), 32'h1);
      check(32'(pl_out[2] ^ pl_out[0]), 32'h0);
    end
    // two planes: segment 0 lit on plane 0 only
    access(16'hFEE0, 8'h01, 1'b1);
    access(16'hFEDC, 8'h49, 1'b1);
    repeat (10) @(posedge clk_sys);
    #1;
    clear = 1'b0;
    repeat (16) @(posedge clk_sys);
    #1;
    check(32'(lit_cnt0), 32'd16);
    check(32'(lit_cnt1), 32'd0);
    // dimmer codes that float the upper segment or plane pins
    dimmer_input_select = 3'h6;
    repeat (3) @(posedge clk_sys);
    #1;
    check(32'(seg_oe), 32'h000FFFFF);
    check(32'(pl_oe), 32'h000000FF);
    dimmer_input_select = 3'h7;
    repeat (3) @(posedge clk_sys);
    #1;
    check(32'(seg_oe), 32'h00FFFFFF);
    check(32'(pl_oe), 32'h0000000F);
    // enable cleared: generator halts with all pins high
    access(16'hFEDC, 8'h41, 1'b1);
    repeat (12) @(posedge clk_sys);
    #1;
    check(32'(seg_out), 32'h00FFFFFF);
    check(32'(pl_out), 32'h000000FF);
    // reset in mid-run: registers and banks return to their reset values
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    check(32'(contrast_code), 32'h3);
    check(32'(seg_oe), 32'h000FFFFF);
    access(16'hFEDD, 8'h00, 1'b0);
    check(32'(rd_val), 32'h00);
    access(16'hFEDC, 8'h00, 1'b0);
    check(32'(rd_val), 32'h47);
    stop_test();
  end
endmodule : lcd_segment_backplane_driver_test
